// >>> logic/fsce_engine.sv
module fsce_engine
(
   input wire logic clk, // System clock, 100 MHz
   input wire logic reset, // Asynchronous reset, active high
   input wire logic reqValid, // Request byte offered
   input wire logic [7:0] reqByte, // Request byte
   input wire logic reqLast, // Last byte of the request frame
   input wire logic reqUnicast, // Frame addressed to this node alone
   input wire logic [7:0] reqSrcEndpoint, // Source endpoint of the frame
   output logic reqReady, // Engine takes the offered byte
   output logic rspValid, // Reply byte offered
   output logic [7:0] rspByte, // Reply byte
   output logic rspLast, // Last byte of the reply frame
   output logic [7:0] rspEndpoint, // Destination endpoint of the reply
   input wire logic rspReady, // Reply sink takes the byte
   input wire logic flashDone, // Flash finished the running operation
   output logic flashProgStb, // Program strobe
   output logic flashEraseStb, // Erase strobe
   output logic flashEraseAll, // Erase covers every block
   output logic [15:0] flashBlock, // Block address
   output logic [15:0] flashOffset, // Byte address within block
   output logic [7:0] flashData // Program data
);
   // ****************************************
   // State
   // ****************************************
   typedef enum logic [2:0]
   {
      ST_HDR = 3'b000,
      ST_CHECK = 3'b001,
      ST_ERASE = 3'b011,
      ST_DATA = 3'b010,
      ST_FIN = 3'b110,
      ST_DRAIN = 3'b111,
      ST_REPLY = 3'b101
   } fsce_state_t;

   fsce_state_t state_q, state_d;
   logic [63:0] hdr_q, hdr_d, rspWord_q, rspWord_d;
   logic [2:0] hdrIdx_q, hdrIdx_d, rspIdx_q, rspIdx_d;
   logic [15:0] count_q, count_d;
   logic [7:0] endpoint_q, endpoint_d, rspByte_q, rspByte_d, cmdData_q, cmdData_d;
   logic short_q, short_d, frameDone_q, frameDone_d, unicast_q, unicast_d, thenWrite_q, thenWrite_d;
   logic rspValid_q, rspValid_d, rspLast_q, rspLast_d, reqReady_q, reqReady_d, cmdValid_q, cmdValid_d;
   fsce_pkg::fsce_op_t cmdOp_q, cmdOp_d;
   logic portReady;

   logic take, blockBad, spanBad, wholeBad;
   logic [7:0] fCmd;
   logic [15:0] fBlock, fOffset, fLen;
   logic [16:0] span;

   // ****************************************
   // Header fields, big-endian slices
   // ****************************************
   assign take = reqValid && reqReady_q;
   assign fCmd = hdr_q[fsce_pkg::POS_CMD +: 8];
   assign fBlock = hdr_q[fsce_pkg::POS_BLOCK +: 16];
   assign fOffset = hdr_q[fsce_pkg::POS_OFFSET +: 16];
   assign fLen = hdr_q[fsce_pkg::POS_LEN +: 16];
   assign span = {1'b0, fOffset} + {1'b0, fLen};
   assign blockBad = (fBlock >= fsce_pkg::BLOCK_COUNT);
   assign spanBad = (span > {1'b0, fsce_pkg::BLOCK_SIZE});
   // Partial erase cannot be honoured, so it is refused rather than widened
   assign wholeBad = (fOffset != 16'h0000) || (fLen != fsce_pkg::BLOCK_SIZE);

   // Sequencer: collect header, validate, run flash work, drain, reply
   always_comb
   begin
      state_d = state_q;
      {hdr_d, hdrIdx_d, short_d, frameDone_d, unicast_d, endpoint_d, thenWrite_d, count_d} =
         {hdr_q, hdrIdx_q, short_q, frameDone_q, unicast_q, endpoint_q, thenWrite_q, count_q};
      {rspWord_d, rspValid_d, rspByte_d, rspIdx_d, rspLast_d, cmdData_d} =
         {rspWord_q, rspValid_q, rspByte_q, rspIdx_q, rspLast_q, cmdData_q};
      cmdValid_d = 1'b0;
      cmdOp_d = cmdOp_q;
      if (take && reqLast)
      begin
         frameDone_d = 1'b1;
      end
      case (state_q)
         ST_HDR:
         begin
            if (take)
            begin
               hdr_d = {hdr_q[55:0], reqByte};
               hdrIdx_d = hdrIdx_q + 3'h1;
               if (hdrIdx_q == 3'h0)
               begin
                  unicast_d = reqUnicast;
                  endpoint_d = reqSrcEndpoint;
               end
               if (hdrIdx_q == fsce_pkg::HDR_LAST_IDX || reqLast)
               begin
                  short_d = (hdrIdx_q != fsce_pkg::HDR_LAST_IDX);
                  state_d = ST_CHECK;
               end
            end
         end
         ST_CHECK:
         begin
            // Default answer: echo code, block and offset, zero length, flag set
            rspWord_d = {fCmd, 8'h01, fBlock, fOffset, 16'h0000};
            thenWrite_d = 1'b0;
            count_d = fsce_pkg::COUNT_RESET;
            state_d = ST_DRAIN;
            if (!short_q)
            begin
               case (fCmd)
                  fsce_pkg::CMD_GEOMETRY:
                  begin
                     rspWord_d = {fsce_pkg::RSP_GEOMETRY, 8'h00, fsce_pkg::BLOCK_COUNT,
                        fsce_pkg::BLOCK_SIZE, 16'h0000};
                  end
                  fsce_pkg::CMD_ERASE:
                  begin
                     rspWord_d = {fsce_pkg::RSP_ERASE, 8'h01, fBlock, fOffset, 16'h0000};
                     // Zero length erases every block and skips the range checks
                     if (fLen == 16'h0000 || (!blockBad && !wholeBad))
                     begin
                        rspWord_d[fsce_pkg::POS_OPT + fsce_pkg::STATUS_ERR_BIT] = 1'b0;
                        cmdValid_d = 1'b1;
                        cmdOp_d = (fLen == 16'h0000) ? fsce_pkg::FSCE_OP_ERASE_ALL :
                           fsce_pkg::FSCE_OP_ERASE_ONE;
                        state_d = ST_ERASE;
                     end
                  end
                  fsce_pkg::CMD_WRITE, fsce_pkg::CMD_ERASE_WRITE:
                  begin
                     rspWord_d = {fCmd | fsce_pkg::RSP_FLAG, 8'h01, fBlock, fOffset, 16'h0000};
                     if (!blockBad && !spanBad)
                     begin
                        rspWord_d[fsce_pkg::POS_OPT + fsce_pkg::STATUS_ERR_BIT] = 1'b0;
                        thenWrite_d = (fCmd == fsce_pkg::CMD_ERASE_WRITE);
                        cmdValid_d = thenWrite_d;
                        cmdOp_d = fsce_pkg::FSCE_OP_ERASE_ONE;
                        state_d = thenWrite_d ? ST_ERASE : ST_DATA;
                     end
                  end
                  default:
                  begin
                     state_d = ST_DRAIN;
                  end
               endcase
            end
         end
         ST_ERASE, ST_FIN:
         begin
            // Programming waits for the erase so no byte lands before it
            if (portReady && !cmdValid_q)
            begin
               state_d = (state_q == ST_ERASE && thenWrite_q) ? ST_DATA : ST_DRAIN;
            end
         end
         ST_DATA:
         begin
            if (count_q == fLen || frameDone_q)
            begin
               state_d = ST_FIN;
            end
            else if (take)
            begin
               cmdValid_d = 1'b1;
               cmdOp_d = fsce_pkg::FSCE_OP_PROG;
               cmdData_d = reqByte;
               count_d = count_q + 16'h0001;
            end
         end
         ST_DRAIN:
         begin
            if (frameDone_q)
            begin
               if (unicast_q)
               begin
                  state_d = ST_REPLY;
                  rspValid_d = 1'b1;
                  rspByte_d = rspWord_q[63:56];
                  rspWord_d = {rspWord_q[55:0], 8'h00};
                  rspIdx_d = 3'h0;
               end
               else
               begin
                  state_d = ST_HDR;
                  frameDone_d = 1'b0;
                  hdrIdx_d = 3'h0;
               end
            end
         end
         ST_REPLY:
         begin
            if (rspReady)
            begin
               if (rspLast_q)
               begin
                  rspValid_d = 1'b0;
                  rspLast_d = 1'b0;
                  state_d = ST_HDR;
                  frameDone_d = 1'b0;
                  hdrIdx_d = 3'h0;
               end
               else
               begin
                  rspByte_d = rspWord_q[63:56];
                  rspWord_d = {rspWord_q[55:0], 8'h00};
                  rspIdx_d = rspIdx_q + 3'h1;
                  rspLast_d = (rspIdx_q == 3'h6);
               end
            end
         end
         default:
         begin
            state_d = ST_HDR;
         end
      endcase
   end

   // Ready is registered, so it looks at the next state and the flash port
   always_comb
   begin
      reqReady_d = 1'b0;
      case (state_d)
         ST_HDR: reqReady_d = 1'b1;
         ST_DRAIN: reqReady_d = !frameDone_d;
         ST_DATA: reqReady_d = portReady && !cmdValid_d && !cmdValid_q && !frameDone_d;
         default: reqReady_d = 1'b0;
      endcase
   end

   // Registers
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         state_q <= ST_HDR;
         cmdOp_q <= fsce_pkg::FSCE_OP_PROG;
         hdr_q <= fsce_pkg::HDR_RESET;
         rspWord_q <= fsce_pkg::HDR_RESET;
         count_q <= fsce_pkg::COUNT_RESET;
         {hdrIdx_q, short_q, frameDone_q, unicast_q, endpoint_q, thenWrite_q} <= 15'h0000;
         {rspValid_q, rspByte_q, rspIdx_q, rspLast_q, reqReady_q, cmdValid_q, cmdData_q} <= 23'h000000;
      end
      else
      begin
         state_q <= state_d;
         cmdOp_q <= cmdOp_d;
         {hdr_q, hdrIdx_q, short_q, frameDone_q, unicast_q, endpoint_q, thenWrite_q, count_q} <=
            {hdr_d, hdrIdx_d, short_d, frameDone_d, unicast_d, endpoint_d, thenWrite_d, count_d};
         {rspWord_q, rspValid_q, rspByte_q, rspIdx_q, rspLast_q, reqReady_q, cmdValid_q, cmdData_q} <=
            {rspWord_d, rspValid_d, rspByte_d, rspIdx_d, rspLast_d, reqReady_d, cmdValid_d, cmdData_d};
      end
   end

   // ****************************************
   // Flash port
   // ****************************************
   fsce_flash_port flashPort
   (
      .clk(clk), .reset(reset), .cmdValid(cmdValid_q), .cmdOp(cmdOp_q), .cmdBlock(fBlock),
      .cmdOffset(fOffset + count_q - 16'h0001),
      .cmdData(cmdData_q), .cmdReady(portReady), .flashDone(flashDone), .flashProgStb(flashProgStb),
      .flashEraseStb(flashEraseStb), .flashEraseAll(flashEraseAll), .flashBlock(flashBlock),
      .flashOffset(flashOffset), .flashData(flashData)
   );

   assign reqReady = reqReady_q;
   assign rspValid = rspValid_q;
   assign rspByte = rspByte_q;
   assign rspLast = rspLast_q;
   assign rspEndpoint = endpoint_q;
endmodule

// >>> logic/fsce_flash_port.sv
module fsce_flash_port
(
   input wire logic clk, // System clock
   input wire logic reset, // Asynchronous reset, active high
   input wire logic cmdValid, // Operation offered
   input wire fsce_pkg::fsce_op_t cmdOp, // Operation kind
   input wire logic [15:0] cmdBlock, // Target block
   input wire logic [15:0] cmdOffset, // Byte offset within block
   input wire logic [7:0] cmdData, // Byte to program
   output logic cmdReady, // Port idle, operation taken when valid
   input wire logic flashDone, // Flash finished the running operation
   output logic flashProgStb, // One-cycle program strobe
   output logic flashEraseStb, // One-cycle erase strobe
   output logic flashEraseAll, // Erase applies to every block
   output logic [15:0] flashBlock, // Block address
   output logic [15:0] flashOffset, // Byte address within block
   output logic [7:0] flashData // Program data
);
   logic ready_q, ready_d;
   logic prog_q, prog_d;
   logic erase_q, erase_d;
   logic all_q, all_d;
   logic [15:0] block_q, block_d;
   logic [15:0] offset_q, offset_d;
   logic [7:0] data_q, data_d;

   // Take one operation, strobe it, then hold busy until the flash reports done
   always_comb
   begin
      ready_d = ready_q;
      prog_d = 1'b0;
      erase_d = 1'b0;
      all_d = all_q;
      block_d = block_q;
      offset_d = offset_q;
      data_d = data_q;
      if (ready_q && cmdValid)
      begin
         ready_d = 1'b0;
         prog_d = (cmdOp == fsce_pkg::FSCE_OP_PROG);
         // Erased cells read back all ones; the macro does the work
         erase_d = (cmdOp != fsce_pkg::FSCE_OP_PROG);
         all_d = (cmdOp == fsce_pkg::FSCE_OP_ERASE_ALL);
         block_d = cmdBlock;
         offset_d = cmdOffset;
         data_d = cmdData;
      end
      else if (!ready_q && flashDone && !prog_q && !erase_q)
      begin
         ready_d = 1'b1;
      end
   end

   // Registers
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         ready_q <= 1'b1;
         prog_q <= 1'b0;
         erase_q <= 1'b0;
         all_q <= 1'b0;
         block_q <= 16'h0000;
         offset_q <= 16'h0000;
         data_q <= 8'h00;
      end
      else
      begin
         ready_q <= ready_d;
         prog_q <= prog_d;
         erase_q <= erase_d;
         all_q <= all_d;
         block_q <= block_d;
         offset_q <= offset_d;
         data_q <= data_d;
      end
   end

   assign cmdReady = ready_q;
   assign flashProgStb = prog_q;
   assign flashEraseStb = erase_q;
   assign flashEraseAll = all_q;
   assign flashBlock = block_q;
   assign flashOffset = offset_q;
   assign flashData = data_q;
endmodule

// >>> logic/fsce_pkg.sv
package fsce_pkg;
   // ****************************************
   // Frame layout
   // ****************************************
   localparam int unsigned HDR_BYTES = 8;
   localparam logic [2:0] HDR_LAST_IDX = 3'h7;
   // Bit positions of the fields inside the 64-bit header, first byte on top
   localparam int unsigned POS_CMD = 56;
   localparam int unsigned POS_OPT = 48;
   localparam int unsigned POS_BLOCK = 32;
   localparam int unsigned POS_OFFSET = 16;
   localparam int unsigned POS_LEN = 0;
   localparam int unsigned STATUS_ERR_BIT = 0;

   // ****************************************
   // Command and reply codes
   // ****************************************
   localparam logic [7:0] CMD_GEOMETRY = 8'h00;
   localparam logic [7:0] CMD_ERASE = 8'h01;
   localparam logic [7:0] CMD_WRITE = 8'h02;
   localparam logic [7:0] CMD_ERASE_WRITE = 8'h03;
   localparam logic [7:0] RSP_GEOMETRY = 8'h80;
   localparam logic [7:0] RSP_ERASE = 8'h81;
   localparam logic [7:0] RSP_FLAG = 8'h80;

   // ****************************************
   // Store geometry and reset values
   // ****************************************
   localparam logic [15:0] BLOCK_COUNT = 16'h00A0;
   localparam logic [15:0] BLOCK_SIZE = 16'h1000;
   localparam logic [63:0] HDR_RESET = 64'h0000_0000_0000_0000;
   localparam logic [15:0] COUNT_RESET = 16'h0000;

   // ****************************************
   // Flash port operations
   // ****************************************
   typedef enum logic [1:0]
   {
      FSCE_OP_PROG = 2'h0,
      FSCE_OP_ERASE_ONE = 2'h1,
      FSCE_OP_ERASE_ALL = 2'h2
   } fsce_op_t;
endpackage

// >>> testbench/fsce_engine_bench.sv
module fsce_engine_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic reqValid = 1'b0;
   logic [7:0] reqByte = 8'h00;
   logic reqLast = 1'b0;
   logic reqUnicast = 1'b0;
   logic [7:0] reqSrcEndpoint = 8'h00;
   logic reqReady, rspValid, rspLast, flashDone, flashProgStb, flashEraseStb, flashEraseAll;
   logic [7:0] rspByte, rspEndpoint, flashData;
   logic rspReady = 1'b1;
   logic [15:0] flashBlock, flashOffset;
   logic [7:0] frm[0:15];
   int err_total = 0;
   int check_count = 0;
   int cycles = 0;

   always #5 clk = ~clk;

   fsce_engine uut (.clk(clk), .reset(reset), .reqValid(reqValid), .reqByte(reqByte), .reqLast(reqLast),
      .reqUnicast(reqUnicast), .reqSrcEndpoint(reqSrcEndpoint), .reqReady(reqReady), .rspValid(rspValid),
      .rspByte(rspByte), .rspLast(rspLast), .rspEndpoint(rspEndpoint), .rspReady(rspReady),
      .flashDone(flashDone), .flashProgStb(flashProgStb), .flashEraseStb(flashEraseStb),
      .flashEraseAll(flashEraseAll), .flashBlock(flashBlock), .flashOffset(flashOffset), .flashData(flashData));

   fsce_flash_model fm (.clk(clk), .reset(reset), .flashProgStb(flashProgStb), .flashEraseStb(flashEraseStb),
      .flashEraseAll(flashEraseAll), .flashBlock(flashBlock), .flashOffset(flashOffset), .flashData(flashData),
      .flashDone(flashDone));

   // ****************************************
   // Checking and closing
   // ****************************************
   task automatic check(input string what, input logic [41:0] seen, input logic [41:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // A hang in any handshake lands here instead of running forever
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         err_total++;
         end_sim();
      end
   end

   // ****************************************
   // Request and reply tasks
   // ****************************************
   // Byte is held until the edge that finds reqReady high
   task automatic send(input int n, input logic uni);
      for (int i = 0; i < n; i++)
      begin
         @(negedge clk);
         reqValid = 1'b1;
         reqByte = frm[i];
         reqLast = (i == n - 1);
         reqUnicast = uni;
         while (reqReady !== 1'b1)
            @(negedge clk);
         @(posedge clk);
      end
      @(negedge clk);
      reqValid = 1'b0;
      reqLast = 1'b0;
   endtask

   // Third byte is stalled one cycle to exercise the hold
   task automatic get_reply(input logic [63:0] exp);
      for (int i = 0; i < 8; i++)
      begin
         @(negedge clk);
         while (rspValid !== 1'b1)
            @(negedge clk);
         if (i == 2)
         begin
            rspReady = 1'b0;
            @(negedge clk);
            rspReady = 1'b1;
         end
         check("reply byte", {34'h0, rspByte}, {34'h0, exp[63 - 8 * i -: 8]});
         check("reply last", {41'h0, rspLast}, {41'h0, i == 7});
         check("reply endpoint", {34'h0, rspEndpoint}, {34'h0, reqSrcEndpoint});
         @(posedge clk);
      end
   endtask

   // Header most significant byte first, payload 10h upward
   task automatic run(input logic [7:0] c, input logic [15:0] b, o, l, input int pay, input logic [63:0] exp);
      frm[0] = c;
      frm[1] = 8'h00;
      {frm[2], frm[3], frm[4], frm[5], frm[6], frm[7]} = {b, o, l};
      for (int i = 0; i < pay; i++)
         frm[8 + i] = 8'h10 + 8'(i);
      send(8 + pay, 1'b1);
      get_reply(exp);
      $display("test command %h block %h done", c, b);
   endtask

   task automatic chk_op(input int idx, input logic [41:0] exp);
      check("flash op", (fm.opLog.size() > idx) ? fm.opLog[idx] : 42'hX, exp);
   endtask

   // ****************************************
   // Test sequence
   // ****************************************
   initial
   begin
      repeat (12) @(negedge clk);
      reset = 1'b0;
      reqSrcEndpoint = 8'hE6;
      run(8'h00, 16'h0000, 16'h0000, 16'h0000, 0, 64'h8000_00A0_1000_0000);
      // Broadcast query must stay silent
      frm[0] = 8'h00;
      send(8, 1'b0);
      repeat (40)
      begin
         @(negedge clk);
         check("broadcast silent", {41'h0, rspValid}, 42'h0);
      end
      $display("test broadcast done");
      reqSrcEndpoint = 8'h5A;
      run(8'h01, 16'h002A, 16'h0000, 16'h1000, 0, 64'h8100_002A_0000_0000);
      chk_op(0, {2'h1, 16'h002A, 24'h0});
      run(8'h01, 16'h0005, 16'h0000, 16'h0000, 0, 64'h8100_0005_0000_0000);
      chk_op(1, {2'h2, 16'h0000, 24'h0});
      run(8'h02, 16'h0016, 16'h0005, 16'h0003, 3, 64'h8200_0016_0005_0000);
      for (int i = 0; i < 3; i++)
         chk_op(2 + i, {2'h0, 16'h0016, 16'h0005 + 16'(i), 8'h10 + 8'(i)});
      run(8'h03, 16'h0007, 16'h0010, 16'h0001, 1, 64'h8300_0007_0010_0000);
      chk_op(5, {2'h1, 16'h0007, 24'h0});
      chk_op(6, {2'h0, 16'h0007, 16'h0010, 8'h10});
      run(8'h02, 16'h00A0, 16'h0000, 16'h0002, 2, 64'h8201_00A0_0000_0000);
      run(8'h03, 16'h0001, 16'h0FFF, 16'h0002, 2, 64'h8301_0001_0FFF_0000);
      run(8'h01, 16'h0002, 16'h0000, 16'h0800, 0, 64'h8101_0002_0000_0000);
      check("flash untouched", 42'(fm.opLog.size()), 42'd7);
      run(8'h07, 16'h0003, 16'h0004, 16'h0000, 0, 64'h0701_0003_0004_0000);
      end_sim();
   end
endmodule

bind fsce_engine fsce_engine_props chk (.clk(clk), .reset(reset), .reqReady(reqReady), .rspValid(rspValid),
   .rspByte(rspByte), .rspLast(rspLast), .rspEndpoint(rspEndpoint), .rspReady(rspReady),
   .flashProgStb(flashProgStb), .flashEraseStb(flashEraseStb));

// >>> testbench/fsce_engine_props.sv
module fsce_engine_props
(
   input wire logic clk, // System clock
   input wire logic reset, // Asynchronous reset, active high
   input wire logic reqReady, // Request byte taken
   input wire logic rspValid, // Reply byte offered
   input wire logic [7:0] rspByte, // Reply byte
   input wire logic rspLast, // Last reply byte
   input wire logic [7:0] rspEndpoint, // Reply destination
   input wire logic rspReady, // Reply sink takes byte
   input wire logic flashProgStb, // Program strobe
   input wire logic flashEraseStb // Erase strobe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] rspIdx_q;
   logic [2:0] rspIdx_d;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   // ****************************************
   // Reply byte position
   // ****************************************
   // Restarts on the last byte so a short reply cannot skew the next one
   always_comb
   begin
      rspIdx_d = rspIdx_q;
      if (rspValid && rspReady)
      begin
         rspIdx_d = rspLast ? 3'h0 : rspIdx_q + 3'h1;
      end
   end

   // Position register
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         rspIdx_q <= 3'h0;
      end
      else
      begin
         rspIdx_q <= rspIdx_d;
      end
   end

   // ****************************************
   // Properties
   // ****************************************
   sequence rspTake;
      rspValid && rspReady;
   endsequence

   sequence lastTake;
      rspTake ##0 rspLast;
   endsequence

   prog_pulse_a: assert property (flashProgStb |=> !flashProgStb) else $error("program strobe too long");
   erase_pulse_a: assert property (flashEraseStb |=> !flashEraseStb) else $error("erase strobe too long");
   strobe_excl_a: assert property (flashEraseStb |-> !flashProgStb) else $error("erase and program together");
   rsp_hold_a: assert property (rspValid && !rspReady |=> rspValid && $stable(rspByte) && $stable(rspLast))
      else $error("reply byte changed while stalled");
   rsp_end_a: assert property (lastTake |=> !rspValid) else $error("reply longer than eight bytes");
   status_rsvd_a: assert property (rspValid && rspIdx_q == 3'h1 |-> rspByte[7:1] == 7'h00)
      else $error("reserved status bits set");
   len_zero_a: assert property (rspValid && rspIdx_q[2:1] == 2'h3 |-> rspByte == 8'h00)
      else $error("reply length not zero");
   last_eighth_a: assert property (rspValid |-> rspLast == (rspIdx_q == 3'h7))
      else $error("last flag off the eighth byte");
   reply_busy_a: assert property (rspValid |-> !reqReady) else $error("request taken during reply");
   ep_hold_a: assert property (rspValid && $past(rspValid) |-> $stable(rspEndpoint))
      else $error("endpoint changed in reply");
endmodule

// >>> testbench/fsce_flash_model.sv
module fsce_flash_model
(
   input wire logic clk, // System clock
   input wire logic reset, // Asynchronous reset, active high
   input wire logic flashProgStb, // Program strobe
   input wire logic flashEraseStb, // Erase strobe
   input wire logic flashEraseAll, // Erase covers every block
   input wire logic [15:0] flashBlock, // Block address
   input wire logic [15:0] flashOffset, // Byte address
   input wire logic [7:0] flashData, // Program data
   output logic flashDone // Operation finished
);
   timeunit 1ns;
   timeprecision 1ps;
   // Each entry: kind, block, offset, data
   logic [41:0] opLog[$];
   int waitCnt;
   int opNum;

   // Alternates prompt and slow completion so the engine must really wait
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         flashDone <= 1'b0;
         waitCnt <= 0;
         opNum <= 0;
         opLog.delete();
      end
      else
      begin
         flashDone <= 1'b0;
         if (flashProgStb)
         begin
            opLog.push_back({2'h0, flashBlock, flashOffset, flashData});
         end
         else if (flashEraseStb)
         begin
            // Block is meaningless for erase-all, logged as zero
            opLog.push_back({flashEraseAll ? 2'h2 : 2'h1, flashEraseAll ? 16'h0000 : flashBlock, 24'h000000});
         end
         if (flashProgStb || flashEraseStb)
         begin
            waitCnt <= (opNum % 2 == 0) ? 1 : 4;
            opNum <= opNum + 1;
         end
         else if (waitCnt == 1)
         begin
            flashDone <= 1'b1;
            waitCnt <= 0;
         end
         else if (waitCnt > 1)
         begin
            waitCnt <= waitCnt - 1;
         end
      end
   end
endmodule
